// ==== common/err_route_if.sv ====
// Carrier between the register bank and the error router.
// Assumes both ends share one clock; no timing lives here.
`timescale 1ns/1ps
interface err_route_if;
  logic [31:0] err_event;
  logic [31:0] mask;
  logic [31:0] sev;
  logic [31:0] fatal_vec;
  logic [31:0] nonfatal_vec;

  modport regs
  (
    output err_event,
    output mask,
    output sev,
    input fatal_vec,
    input nonfatal_vec
  );

  modport router
  (
    input err_event,
    input mask,
    input sev,
    output fatal_vec,
    output nonfatal_vec
  );
endinterface

// ==== common/err_route_pkg.sv ====
// Constants for the link uncorrectable error mask and severity bank.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package err_route_pkg;

  // Register byte offsets
  localparam logic [11:0] MASK_OFFSET = 12'h108;
  localparam logic [11:0] SEV_OFFSET = 12'h10C;

  // Field positions, shared by mask and severity
  localparam int LINK_RESET_TIMEOUT_BIT = 21;
  localparam int UNSUPPORTED_REQUEST_BIT = 20;
  localparam int MALFORMED_PACKET_BIT = 18;
  localparam int RX_BUFFER_OVERFLOW_BIT = 17;
  localparam int UNEXPECTED_COMPLETION_BIT = 16;
  localparam int COMPLETER_ABORT_BIT = 15;
  localparam int COMPLETION_TIMEOUT_BIT = 14;
  localparam int FLOW_CONTROL_ERROR_BIT = 13;
  localparam int POISONED_PACKET_BIT = 12;
  localparam int SURPRISE_LINK_DOWN_BIT = 5;
  localparam int LINK_LAYER_PROTOCOL_BIT = 4;
  localparam int TRAINING_ERROR_BIT = 0;

  // Implemented bits; everything else is reserved and reads zero
  localparam logic [31:0] WRITABLE_BITS = 32'h0037_F031;
  // Error sources that reach the logs; training error is excluded
  localparam logic [31:0] ROUTED_BITS = 32'h0037_F030;

  // Values after power-on reset
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] SEV_RESET = 32'h0026_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    SEL_NONE = 2'b00,
    SEL_MASK = 2'b01,
    SEL_SEV = 2'b10
  } reg_sel_t;

endpackage

// ==== logic/err_mask_sev_regs.sv ====
// Link uncorrectable error mask and severity registers, AXI4-Lite slave.
// Assumes aclk at 100 MHz; porst_n is the power-on reset, aresetn any reset.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module err_mask_sev_regs
  import err_route_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic porst_n,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Recorded errors from the status register, one pulse per error
  input wire logic [31:0] err_event,
  // Routed errors toward the first and next error logs
  output logic [31:0] fatal_err_vec,
  output logic [31:0] nonfatal_err_vec,
  output logic fatal_err,
  output logic nonfatal_err
);

  function automatic reg_sel_t reg_select(input logic [ADDR_W-1:0] addr);
    if (addr[11:0] == MASK_OFFSET)
      return SEL_MASK;
    else if (addr[11:0] == SEV_OFFSET)
      return SEL_SEV;
    else
      return SEL_NONE;
  endfunction

  err_route_if rif();

  // Write channel state
  logic aw_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic next_aw_full;
  logic [ADDR_W-1:0] next_aw_addr;
  logic next_w_full;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic wr_commit;
  reg_sel_t wr_sel;
  logic [31:0] strb_bits;

  // Read channel state
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  reg_sel_t rd_sel;

  // Sticky field state
  logic [31:0] mask;
  logic [31:0] sev;
  logic [31:0] next_mask;
  logic [31:0] next_sev;

  // A full response blocks new beats so one write is under way at a time
  assign awready = !aw_full && !bvalid_q;
  assign wready = !w_full && !bvalid_q;
  assign arready = !rvalid_q;
  assign wr_commit = aw_full && w_full && !bvalid_q;
  assign wr_sel = reg_select(aw_addr_q);
  assign rd_sel = reg_select(araddr);

  always_comb
  begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr_q;
    next_w_full = w_full;
    next_w_data = w_data_q;
    next_w_strb = w_strb_q;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    if (awvalid && awready)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (wr_commit)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bvalid_q && bready)
      next_bvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr_q <= '0;
      w_full <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      aw_addr_q <= next_aw_addr;
      w_full <= next_w_full;
      w_data_q <= next_w_data;
      w_strb_q <= next_w_strb;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Unmapped reads answer zero with an error response
  always_comb
  begin
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (rd_sel == SEL_MASK)
        next_rdata = mask & WRITABLE_BITS;
      else if (rd_sel == SEL_SEV)
        next_rdata = sev & WRITABLE_BITS;
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
    else if (rvalid_q && rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Byte strobes widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_strb
      assign strb_bits[gi*8 +: 8] = {8{w_strb_q[gi]}};
    end
  endgenerate

  // Training error bit is stored but routes nothing: its effect is undefined
  // Writes are dropped during warm reset so the sticky fields hold
  always_comb
  begin
    next_mask = mask;
    next_sev = sev;
    if (aresetn && wr_commit && wr_sel == SEL_MASK)
      next_mask = ((mask & ~strb_bits) | (w_data_q & strb_bits))
        & WRITABLE_BITS;
    if (aresetn && wr_commit && wr_sel == SEL_SEV)
      next_sev = ((sev & ~strb_bits) | (w_data_q & strb_bits))
        & WRITABLE_BITS;
  end

  // Only power-on reset loads MASK_RESET and SEV_RESET into the fields, so they survive warm resets
  always_ff @(posedge aclk)
  begin
    if (!porst_n)
    begin
      mask <= MASK_RESET;
      sev <= SEV_RESET;
    end
    else
    begin
      mask <= next_mask;
      sev <= next_sev;
    end
  end

  assign rif.err_event = err_event;
  assign rif.mask = mask;
  assign rif.sev = sev;

  err_router u_router
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .rt(rif.router)
  );

  assign fatal_err_vec = rif.fatal_vec;
  assign nonfatal_err_vec = rif.nonfatal_vec;
  assign fatal_err = |rif.fatal_vec;
  assign nonfatal_err = |rif.nonfatal_vec;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !porst_n);

  sequence s_mask_write;
    wr_commit && wr_sel == SEL_MASK && w_strb_q == 4'hF;
  endsequence

  sequence s_sev_write;
    wr_commit && wr_sel == SEL_SEV && w_strb_q == 4'hF;
  endsequence

  a_masked_not_signalled: assert property (
    |(err_event & mask) |=>
      ((fatal_err_vec | nonfatal_err_vec) & $past(err_event & mask)) == 0)
    else $error("masked error was signalled");

  a_fatal_route_exact: assert property (
    ##1 fatal_err_vec == $past(err_event & ~mask & sev & ROUTED_BITS))
    else $error("fatal routing mismatch");

  a_nonfatal_route_exact: assert property (
    ##1 nonfatal_err_vec == $past(err_event & ~mask & ~sev & ROUTED_BITS))
    else $error("nonfatal routing mismatch");

  a_logs_disjoint: assert property (
    (fatal_err_vec & nonfatal_err_vec) == 0 && (fatal_err == |fatal_err_vec))
    else $error("error routed to both logs");

  a_reserved_read_zero: assert property (
    rvalid |-> (rdata & ~WRITABLE_BITS) == 0)
    else $error("reserved bits read nonzero");

  a_mask_write_lands: assert property (
    s_mask_write |=> mask == ($past(w_data_q) & WRITABLE_BITS) && bvalid)
    else $error("mask write not stored");

  a_sev_write_lands: assert property (
    s_sev_write |=> sev == ($past(w_data_q) & WRITABLE_BITS) && bvalid)
    else $error("severity write not stored");

  a_write_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  a_read_answer_next: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered next cycle");

  a_sticky_warm_reset: assert property (
    disable iff (!porst_n)
    !aresetn |=> mask == $past(mask) && sev == $past(sev))
    else $error("field lost over warm reset");

  a_power_on_defaults: assert property (
    disable iff (1'b0)
    !porst_n |=> mask == MASK_RESET && sev == SEV_RESET)
    else $error("power-on defaults wrong");

endmodule

// ==== logic/err_router.sv ====
// Error router: gates recorded errors by mask, splits them by severity.
// Assumes err_event pulses come from the status register set logic.
`timescale 1ns/1ps
module err_router
  import err_route_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bank side
  err_route_if.router rt
);

  logic [31:0] fatal_q;
  logic [31:0] nonfatal_q;
  logic [31:0] next_fatal;
  logic [31:0] next_nonfatal;
  logic [31:0] unmasked;

  always_comb
  begin
    unmasked = rt.err_event & ~rt.mask & ROUTED_BITS;
    next_fatal = unmasked & rt.sev;
    next_nonfatal = unmasked & ~rt.sev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fatal_q <= 32'h0000_0000;
      nonfatal_q <= 32'h0000_0000;
    end
    else
    begin
      fatal_q <= next_fatal;
      nonfatal_q <= next_nonfatal;
    end
  end

  assign rt.fatal_vec = fatal_q;
  assign rt.nonfatal_vec = nonfatal_q;

endmodule

// ==== testbench/err_source_model.sv ====
// Far-side model: status set logic that pulses recorded errors.
// Assumes the bench names the bits one cycle ahead of each pulse.
`timescale 1ns/1ps
module err_source_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench request
  input wire logic [31:0] req_bits,
  // Pulses toward the bank
  output logic [31:0] err_event
);
  // Registered so every pulse is clean and follows the bench request by one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_event <= '0;
    else
      err_event <= req_bits;
  end
endmodule

// ==== testbench/uncorrectable_error_mask_severity_test.sv ====
// Bench for the mask and severity bank: bus, resets, error routing.
// Assumes the bank follows its AXI4-Lite hand-over timing.
`timescale 1ns/1ps
module uncorrectable_error_mask_severity_test
  import err_route_pkg::*;
;
  logic aclk = 0, aresetn = 0, porst_n = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, req_bits = '0, err_event;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, fatal_err, nonfatal_err;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, fatal_err_vec, nonfatal_err_vec, m_mask, m_sev, rnd;
  integer seed;
  logic [33:0] rd_q[$];
  logic [1:0] b_q[$];
  logic [65:0] ev_q[$];
  logic ev_due = 0;
  logic late_b = 0;
  int n_mismatch = 0, n_tests = 0, cycles = 0;

  always #5 aclk = ~aclk;

  err_mask_sev_regs #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .porst_n(porst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .err_event(err_event), .fatal_err_vec(fatal_err_vec),
    .nonfatal_err_vec(nonfatal_err_vec), .fatal_err(fatal_err),
    .nonfatal_err(nonfatal_err));

  err_source_model i_src (.aclk(aclk), .aresetn(aresetn),
    .req_bits(req_bits), .err_event(err_event));

  task automatic note(input logic [65:0] got, input logic [65:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
    note({64'h0, got}, {64'h0, exp});
  endtask

  task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
    note({32'h0, got}, {32'h0, exp});
  endtask

  task automatic chk_ev(input logic [65:0] got, input logic [65:0] exp);
    note(got, exp);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic [31:0] sb;
    b_q.push_back(r);
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= a;
    wdata <= d;
    bready <= !late_b;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end
    while (!bvalid);
    // A late bready leaves the response waiting one cycle
    if (late_b)
    begin
      bready <= 1;
      @(posedge aclk);
    end
    bready <= 0;
    sb = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    if (a == MASK_OFFSET)
      m_mask = ((m_mask & ~sb) | (d & sb)) & WRITABLE_BITS;
    if (a == SEV_OFFSET)
      m_sev = ((m_sev & ~sb) | (d & sb)) & WRITABLE_BITS;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
    end
    while (!rvalid);
    rready <= 0;
  endtask

  task automatic fire(input logic [31:0] b);
    logic [31:0] v;
    v = b & ~m_mask & ROUTED_BITS;
    if (b != '0)
      ev_q.push_back({|(v & m_sev), |(v & ~m_sev), v & m_sev, v & ~m_sev});
    @(posedge aclk);
    req_bits <= b;
    // Status logic pulses each error for one cycle only
    @(posedge aclk);
    req_bits <= '0;
  endtask

  task automatic reg_check();
    repeat (4) @(posedge aclk);
    rd(MASK_OFFSET, {RESP_OKAY, m_mask});
    rd(SEV_OFFSET, {RESP_OKAY, m_sev});
  endtask

  always @(posedge aclk)
  begin
    if (bvalid && bready)
      chk_b(bresp, b_q.pop_front());
    if (rvalid && rready)
      chk_rd({rresp, rdata}, rd_q.pop_front());
    if (ev_due)
      chk_ev({fatal_err, nonfatal_err, fatal_err_vec, nonfatal_err_vec},
        ev_q.pop_front());
    ev_due <= err_event != '0;
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial
  begin
    seed = 32'h14CD;
    m_mask = 32'h0000_0000;
    m_sev = 32'h0026_0000;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    porst_n <= 1;
    reg_check();
    fire(32'hFFFF_FFFF);
    fire(32'h0002_0000);
    fire(32'h0010_0000);
    fire(32'h0000_0001);
    wr(MASK_OFFSET, 32'hFFFF_FFFE, RESP_OKAY);
    rd(MASK_OFFSET, {RESP_OKAY, 32'h0037_F030});
    wr(SEV_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
    rd(SEV_OFFSET, {RESP_OKAY, 32'h0037_F031});
    fire(32'hFFFF_FFFF);
    // Unmapped places must neither store nor return data
    wr(12'h104, 32'h0000_0000, RESP_SLVERR);
    rd(12'h110, {RESP_SLVERR, 32'h0});
    reg_check();
    repeat (20)
    begin
      // Random strobes and a late bready exercise lanes and response hold
      rnd = $random(seed);
      wstrb <= rnd[3:0];
      late_b = rnd[4];
      // Training error bit kept clear, as software must
      wr(MASK_OFFSET, $random(seed) & 32'hFFFF_FFFE, RESP_OKAY);
      wr(SEV_OFFSET, $random(seed), RESP_OKAY);
      repeat (4) fire($random(seed));
      fire(32'h0);
      reg_check();
    end
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    reg_check();
    porst_n <= 0;
    repeat (3) @(posedge aclk);
    porst_n <= 1;
    m_mask = 32'h0000_0000;
    m_sev = 32'h0026_0000;
    reg_check();
    repeat (4) @(posedge aclk);
    wrap_up();
  end
endmodule
